// file: hw/lsrc_pkg.sv
// Constants, register map and state codes for the logon and sync retry control block
package lsrc_pkg;

  localparam int TMR_W = 32;
  localparam int NUM_TMR = 4;
  localparam int T_CONT = 0;
  localparam int T_BACK = 1;
  localparam int T_SYNC = 2;
  localparam int NUM_SYNC = 2;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_MASK = 6'h08;
  localparam logic [5:0] OFS_SFLABEL = 6'h0C;
  localparam logic [5:0] OFS_CONT_WAIT = 6'h10;
  localparam logic [5:0] OFS_CONT_LIMIT = 6'h14;
  localparam logic [5:0] OFS_BACKOFF = 6'h18;
  localparam logic [5:0] OFS_COARSE_WAIT = 6'h1C;
  localparam logic [5:0] OFS_FINE_WAIT = 6'h20;
  localparam logic [5:0] OFS_LOSS_LIMITS = 6'h24;
  localparam logic [5:0] OFS_COUNTS = 6'h28;

  localparam int CTRL_EN = 0;
  localparam int CTRL_GO = 1;

  localparam int STAT_W = 7;
  localparam int ST_COLLIDE = 0;
  localparam int ST_ABANDON = 1;
  localparam int ST_LOGON_OK = 2;
  localparam int ST_COARSE_FAIL = 3;
  localparam int ST_FINE_FAIL = 4;
  localparam int ST_STANDBY = 5;
  localparam int ST_DESC = 6;

  localparam int CNT_ATT_LSB = 0;
  localparam int CNT_COARSE_LSB = 8;
  localparam int CNT_FINE_LSB = 16;
  localparam int CNT_STATE_LSB = 24;
  localparam int LIM_FINE_LSB = 8;

  localparam int BUF_BYTES = 10;
  localparam logic [7:0] CONT_BODY = 8'h0A;
  localparam logic [7:0] CORR_BODY = 8'h0A;
  localparam int CONT_LABEL_IDX = 0;
  localparam int CONT_WAIT_IDX = 1;
  localparam int CONT_LIMIT_IDX = 5;
  localparam int CONT_BACKOFF_IDX = 6;
  localparam int CORR_CWAIT_IDX = 0;
  localparam int CORR_FWAIT_IDX = 4;
  localparam int CORR_CLIM_IDX = 8;
  localparam int CORR_FLIM_IDX = 9;

  localparam logic [31:0] RST_WAIT = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_BACKOFF = 32'h0000_0000;
  localparam logic [7:0] RST_LIMIT = 8'h01;
  localparam logic [7:0] RST_SFLABEL = 8'h00;
  localparam logic [31:0] LFSR_SEED = 32'h1357_9BDF;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

  typedef enum logic [3:0] {
    LG_IDLE = 4'b0001,
    LG_SEND = 4'b0010,
    LG_WAIT = 4'b0100,
    LG_BACKOFF = 4'b1000
  } lsrc_logon_e;

  typedef enum logic [2:0] {
    PS_KIND = 3'b001,
    PS_LEN = 3'b010,
    PS_BODY = 3'b100
  } lsrc_parse_e;

endpackage

// file: hw/lsrc_timer_if.sv
// Handshake between the control block and one reply or backoff timer
`timescale 1ns/1ps
interface lsrc_timer_if;
  logic start;
  logic cancel;
  logic tick;
  logic [lsrc_pkg::TMR_W-1:0] limit;
  logic expire;
  logic busy;
  modport ctl (output start, output cancel, output tick, output limit, input expire, input busy);
  modport tmr (input start, input cancel, input tick, input limit, output expire, output busy);
endinterface

// file: hw/lsrc_reply_timer.sv
// Interval timer counting PCR ticks up to a limit latched at start
`timescale 1ns/1ps
module lsrc_reply_timer (
  input wire logic mclk,
  input wire logic srst,
  lsrc_timer_if.tmr tif
);
  logic [lsrc_pkg::TMR_W-1:0] count;
  logic [lsrc_pkg::TMR_W-1:0] lim;
  logic busy;
  logic expire;
  wire reached = busy & (count >= lim);

  assign tif.busy = busy;
  assign tif.expire = expire;

  // Limit latched so a later descriptor cannot stretch a running wait
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      busy <= 1'b0;
      count <= '0;
      lim <= '0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= reached & ~tif.start & ~tif.cancel;
      if (tif.start)
      begin
        busy <= 1'b1;
        count <= '0;
        lim <= tif.limit;
      end
      else if (tif.cancel | reached)
        busy <= 1'b0;
      else if (busy & tif.tick)
        count <= count + {{(lsrc_pkg::TMR_W - 1){1'b0}}, 1'b1};
    end
  end
endmodule

// file: hw/lsrc_top.sv
// Descriptor parser, logon retry and sync loss control with Avalon-MM registers
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Overview of operation
// [R1] Every descriptor opens with a kind byte and a byte count of the payload after the count.
// [R2] The contention payload is label, 32-bit reply wait, 8-bit attempt limit, 32-bit backoff, for the label only.
// [R3] The contention reply wait runs in PCR ticks from the last logon burst and its expiry means a collision.
// [R4] Failed logon attempts are counted and the logon is abandoned when the count reaches the attempt limit.
// [R5] The backoff ceiling bounds, in PCR ticks, the gap from reply wait expiry to the next logon burst.
// [R6] After an expiry below the limit a random wait from 0 to the ceiling precedes a new logon burst.
// [R7] The sender places reserved bits ahead of information bits and drives them to zero when not encrypted.
// [R8] The correction payload is coarse wait, fine wait, coarse loss limit, fine loss limit, with no label.
// [R9] The coarse reply wait runs after each coarse burst and its expiry marks that burst failed.
// [R10] The fine reply wait runs after each fine burst and its expiry marks that burst failed.
// [R11] Consecutive coarse failures are counted and reaching the coarse limit sends the terminal to stand-by.
// [R12] Consecutive fine failures are counted and reaching the fine limit sends the terminal to stand-by.
// [R13] Reserved bit values in received descriptors are ignored.
// [R14] A correction inside its reply wait clears that loss counter.
// [R15] A descriptor of unknown kind is skipped by its byte count.
module lsrc_top #(
  parameter logic [7:0] CONT_KIND = 8'hC1,
  parameter logic [7:0] CORR_KIND = 8'hC2
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic desc_restart,
  input wire logic desc_valid,
  input wire logic [7:0] desc_byte,
  input wire logic pcr_tick,
  input wire logic logon_burst_sent,
  input wire logic logon_reply,
  input wire logic coarse_burst_sent,
  input wire logic coarse_correction,
  input wire logic fine_burst_sent,
  input wire logic fine_correction,
  output logic logon_burst_req,
  output logic logon_abandon,
  output logic standby_req,
  output logic irq
);
  lsrc_timer_if tif[lsrc_pkg::NUM_TMR] ();

  logic ctrl_en;
  logic [lsrc_pkg::STAT_W-1:0] status;
  logic [lsrc_pkg::STAT_W-1:0] mask;
  logic [7:0] sf_label;
  logic [31:0] cont_wait;
  logic [7:0] cont_limit;
  logic [31:0] backoff_ceiling;
  logic [31:0] sync_wait [lsrc_pkg::NUM_SYNC];
  logic [7:0] loss_limit [lsrc_pkg::NUM_SYNC];
  logic [7:0] loss_count [lsrc_pkg::NUM_SYNC];
  logic [7:0] attempts;
  logic [31:0] lfsr;
  lsrc_pkg::lsrc_logon_e lg_state;
  lsrc_pkg::lsrc_logon_e next_lg_state;
  lsrc_pkg::lsrc_parse_e ps_state;
  logic [7:0] kind;
  logic [7:0] len;
  logic [7:0] idx;
  logic [7:0] body_buf [lsrc_pkg::BUF_BYTES];
  logic done_q;
  logic [7:0] done_kind;
  logic [7:0] done_len;

  // Bus decode
  wire bus_req = avs_read | avs_write;
  wire wr_en = avs_write & ~avs_waitrequest;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wbits = avs_writedata & wmask;
  wire sel_ctrl = avs_address == lsrc_pkg::OFS_CTRL;
  wire sel_status = avs_address == lsrc_pkg::OFS_STATUS;
  wire sel_mask = avs_address == lsrc_pkg::OFS_MASK;
  wire sel_sflabel = avs_address == lsrc_pkg::OFS_SFLABEL;
  wire sel_cont_wait = avs_address == lsrc_pkg::OFS_CONT_WAIT;
  wire sel_cont_limit = avs_address == lsrc_pkg::OFS_CONT_LIMIT;
  wire sel_backoff = avs_address == lsrc_pkg::OFS_BACKOFF;
  wire sel_coarse_wait = avs_address == lsrc_pkg::OFS_COARSE_WAIT;
  wire sel_fine_wait = avs_address == lsrc_pkg::OFS_FINE_WAIT;
  wire sel_loss_limits = avs_address == lsrc_pkg::OFS_LOSS_LIMITS;
  wire sel_counts = avs_address == lsrc_pkg::OFS_COUNTS;
  wire logon_go = wr_en & sel_ctrl & wbits[lsrc_pkg::CTRL_GO] & ctrl_en;
  wire [lsrc_pkg::STAT_W-1:0] status_clr = (wr_en & sel_status) ? wbits[lsrc_pkg::STAT_W-1:0] : '0;

  wire [31:0] counts_word = {4'h0, lg_state, loss_count[1], loss_count[0], attempts};
  wire [31:0] limits_word = {16'h0000, loss_limit[1], loss_limit[0]};
  // Unmapped offsets read as zero
  wire [31:0] rd_mux =
    sel_ctrl ? {31'h0000_0000, ctrl_en} :
    sel_status ? {{(32 - lsrc_pkg::STAT_W){1'b0}}, status} :
    sel_mask ? {{(32 - lsrc_pkg::STAT_W){1'b0}}, mask} :
    sel_sflabel ? {24'h00_0000, sf_label} :
    sel_cont_wait ? cont_wait :
    sel_cont_limit ? {24'h00_0000, cont_limit} :
    sel_backoff ? backoff_ceiling :
    sel_coarse_wait ? sync_wait[0] :
    sel_fine_wait ? sync_wait[1] :
    sel_loss_limits ? limits_word :
    sel_counts ? counts_word : 32'h0000_0000;

  // One wait cycle per access keeps the read mux off the bus timing path
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl_en <= 1'b0;
      mask <= '0;
      sf_label <= lsrc_pkg::RST_SFLABEL;
    end
    else if (wr_en)
    begin
      if (sel_ctrl & avs_byteenable[0])
        ctrl_en <= avs_writedata[lsrc_pkg::CTRL_EN];
      if (sel_mask)
        mask <= (mask & ~wmask[lsrc_pkg::STAT_W-1:0]) | wbits[lsrc_pkg::STAT_W-1:0];
      if (sel_sflabel & avs_byteenable[0])
        sf_label <= avs_writedata[7:0];
    end
  end

  // Descriptor parser
  wire body_last = (ps_state == lsrc_pkg::PS_BODY) & (8'(idx + 8'h01) == len);
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ps_state <= lsrc_pkg::PS_KIND;
      kind <= 8'h00;
      len <= 8'h00;
      idx <= 8'h00;
    end
    else if (desc_restart)
      ps_state <= lsrc_pkg::PS_KIND;
    else if (desc_valid)
    begin
      // [R1] Kind then count
      unique case (ps_state)
        lsrc_pkg::PS_KIND:
        begin
          kind <= desc_byte;
          ps_state <= lsrc_pkg::PS_LEN;
        end
        lsrc_pkg::PS_LEN:
        begin
          len <= desc_byte;
          idx <= 8'h00;
          ps_state <= (desc_byte == 8'h00) ? lsrc_pkg::PS_KIND : lsrc_pkg::PS_BODY;
        end
        lsrc_pkg::PS_BODY:
        begin
          // [R15] Skip by count
          idx <= 8'(idx + 8'h01);
          if (body_last)
            ps_state <= lsrc_pkg::PS_KIND;
        end
      endcase
    end
  end

  // Bytes past the known payload are dropped, so longer descriptors still parse
  always_ff @(posedge mclk)
  begin
    if (desc_valid & ~desc_restart & (ps_state == lsrc_pkg::PS_BODY) & (idx < 8'(lsrc_pkg::BUF_BYTES)))
      body_buf[idx[3:0]] <= desc_byte;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      done_q <= 1'b0;
      done_kind <= 8'h00;
      done_len <= 8'h00;
    end
    else
    begin
      done_q <= desc_valid & ~desc_restart & body_last;
      done_kind <= kind;
      done_len <= len;
    end
  end

  function automatic logic [31:0] get32(input int i);
    get32 = {body_buf[i], body_buf[i + 1], body_buf[i + 2], body_buf[i + 3]};
  endfunction

  // [R13] Whole-byte fields only, reserved bits never examined
  wire [7:0] f_label = body_buf[lsrc_pkg::CONT_LABEL_IDX];
  // [R2] Contention fields for own superframe
  wire cont_take = done_q & (done_kind == CONT_KIND) & (done_len >= lsrc_pkg::CONT_BODY) & (f_label == sf_label);
  // [R8] Correction fields, unlabelled
  wire corr_take = done_q & (done_kind == CORR_KIND) & (done_len >= lsrc_pkg::CORR_BODY);

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cont_wait <= lsrc_pkg::RST_WAIT;
      cont_limit <= lsrc_pkg::RST_LIMIT;
      backoff_ceiling <= lsrc_pkg::RST_BACKOFF;
      sync_wait[0] <= lsrc_pkg::RST_WAIT;
      sync_wait[1] <= lsrc_pkg::RST_WAIT;
      loss_limit[0] <= lsrc_pkg::RST_LIMIT;
      loss_limit[1] <= lsrc_pkg::RST_LIMIT;
    end
    else
    begin
      if (cont_take)
      begin
        cont_wait <= get32(lsrc_pkg::CONT_WAIT_IDX);
        cont_limit <= body_buf[lsrc_pkg::CONT_LIMIT_IDX];
        backoff_ceiling <= get32(lsrc_pkg::CONT_BACKOFF_IDX);
      end
      if (corr_take)
      begin
        sync_wait[0] <= get32(lsrc_pkg::CORR_CWAIT_IDX);
        sync_wait[1] <= get32(lsrc_pkg::CORR_FWAIT_IDX);
        loss_limit[0] <= body_buf[lsrc_pkg::CORR_CLIM_IDX];
        loss_limit[1] <= body_buf[lsrc_pkg::CORR_FLIM_IDX];
      end
    end
  end

  // Timers
  genvar t;
  generate
    for (t = 0; t < lsrc_pkg::NUM_TMR; t++)
    begin : g_tmr
      assign tif[t].tick = pcr_tick;
      lsrc_reply_timer u_tmr (
        .mclk(mclk),
        .srst(srst),
        .tif(tif[t])
      );
    end
  endgenerate

  // Logon retry
  wire cont_expire = tif[lsrc_pkg::T_CONT].expire;
  wire back_expire = tif[lsrc_pkg::T_BACK].expire;
  wire in_wait = lg_state == lsrc_pkg::LG_WAIT;
  wire logon_ok = in_wait & logon_reply & ctrl_en;
  wire collide = in_wait & cont_expire & ~logon_reply & ctrl_en;
  // [R4] Limit reached on this failure
  wire att_hit = ({1'b0, attempts} + 9'h001) >= {1'b0, cont_limit};
  wire abandon = collide & att_hit;

  always_comb
  begin
    next_lg_state = lg_state;
    if (~ctrl_en)
      next_lg_state = lsrc_pkg::LG_IDLE;
    else
    begin
      unique case (lg_state)
        lsrc_pkg::LG_IDLE:
          if (logon_go)
            next_lg_state = lsrc_pkg::LG_SEND;
        lsrc_pkg::LG_SEND:
          if (logon_burst_sent)
            next_lg_state = lsrc_pkg::LG_WAIT;
        lsrc_pkg::LG_WAIT:
          if (logon_ok | abandon)
            next_lg_state = lsrc_pkg::LG_IDLE;
          else if (collide)
            next_lg_state = lsrc_pkg::LG_BACKOFF;
        lsrc_pkg::LG_BACKOFF:
          if (back_expire)
            next_lg_state = lsrc_pkg::LG_SEND;
      endcase
    end
  end

  // [R3] Reply wait from each logon burst
  assign tif[lsrc_pkg::T_CONT].start = ctrl_en & (lg_state == lsrc_pkg::LG_SEND) & logon_burst_sent;
  assign tif[lsrc_pkg::T_CONT].cancel = logon_ok | ~ctrl_en;
  assign tif[lsrc_pkg::T_CONT].limit = cont_wait;
  // [R5] Backoff from expiry to next burst
  // [R6] Random draw within the ceiling
  assign tif[lsrc_pkg::T_BACK].start = collide & ~att_hit;
  assign tif[lsrc_pkg::T_BACK].cancel = ~ctrl_en;
  assign tif[lsrc_pkg::T_BACK].limit = lfsr & backoff_ceiling;

  // Masking keeps the draw bounded without a divider, at some cost in uniformity
  always_ff @(posedge mclk)
  begin
    if (srst)
      lfsr <= lsrc_pkg::LFSR_SEED;
    else
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ lsrc_pkg::LFSR_TAPS) : (lfsr >> 1);
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      lg_state <= lsrc_pkg::LG_IDLE;
      attempts <= 8'h00;
      logon_burst_req <= 1'b0;
      logon_abandon <= 1'b0;
    end
    else
    begin
      lg_state <= next_lg_state;
      logon_burst_req <= (next_lg_state == lsrc_pkg::LG_SEND) & (lg_state != lsrc_pkg::LG_SEND);
      logon_abandon <= abandon;
      // [R4] Count failed attempts
      if (logon_go)
        attempts <= 8'h00;
      else if (collide)
        attempts <= 8'(attempts + 8'h01);
    end
  end

  // Coarse and fine sync loss tracking
  wire [1:0] sync_sent = {fine_burst_sent, coarse_burst_sent};
  wire [1:0] sync_corr = {fine_correction, coarse_correction};
  logic [1:0] sync_fail;
  logic [1:0] sync_drop;
  genvar g;
  generate
    for (g = 0; g < lsrc_pkg::NUM_SYNC; g++)
    begin : g_sync
      wire corr_hit = sync_corr[g] & tif[lsrc_pkg::T_SYNC + g].busy;
      wire lim_hit = ({1'b0, loss_count[g]} + 9'h001) >= {1'b0, loss_limit[g]};
      // [R9] Coarse wait per burst
      // [R10] Fine wait per burst
      assign tif[lsrc_pkg::T_SYNC + g].start = ctrl_en & sync_sent[g];
      assign tif[lsrc_pkg::T_SYNC + g].cancel = corr_hit | ~ctrl_en;
      assign tif[lsrc_pkg::T_SYNC + g].limit = sync_wait[g];
      assign sync_fail[g] = tif[lsrc_pkg::T_SYNC + g].expire & ~sync_corr[g];
      assign sync_drop[g] = sync_fail[g] & lim_hit;
      always_ff @(posedge mclk)
      begin
        if (srst)
          loss_count[g] <= 8'h00;
        // [R14] Timely correction clears
        else if (corr_hit | ~ctrl_en)
          loss_count[g] <= 8'h00;
        // [R11] [R12] Consecutive loss count
        else if (sync_fail[g])
          loss_count[g] <= lim_hit ? 8'h00 : 8'(loss_count[g] + 8'h01);
      end
    end
  endgenerate

  // Status: a new event beats a same-cycle clear
  wire [lsrc_pkg::STAT_W-1:0] events = {cont_take | corr_take, |sync_drop, sync_fail[1], sync_fail[0], logon_ok,
    abandon, collide};
  wire [lsrc_pkg::STAT_W-1:0] next_status = (status & ~status_clr) | events;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      status <= '0;
      irq <= 1'b0;
      standby_req <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq <= |(next_status & mask);
      // [R11] [R12] Back to stand-by
      standby_req <= |sync_drop;
    end
  end
endmodule

// file: tb/lsrc_top_asserts.sv
// Port-level assertions for the logon and sync retry control block
`timescale 1ns/1ps
module lsrc_top_asserts (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic logon_burst_req,
  input wire logic logon_abandon,
  input wire logic standby_req,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  wire wr_done = avs_write && !avs_waitrequest;
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 6'h28 |=> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_req_pulse: assert property (logon_burst_req |=> !logon_burst_req)
    else $error("logon request longer than one cycle");
  a_abandon_pulse: assert property (logon_abandon |=> !logon_abandon)
    else $error("abandon longer than one cycle");
  a_abandon_final: assert property (logon_abandon |-> !logon_burst_req ##1 !logon_burst_req)
    else $error("logon request issued at abandon");
  a_standby_pulse: assert property (standby_req |=> !standby_req)
    else $error("standby request longer than one cycle");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_done, 1) || $past(wr_done, 2))
    else $error("interrupt dropped without a register write");
endmodule

bind lsrc_top lsrc_top_asserts u_lsrc_top_asserts (.mclk(mclk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .logon_burst_req(logon_burst_req), .logon_abandon(logon_abandon), .standby_req(standby_req), .irq(irq));

// file: tb/lsrc_ncc_model.sv
// Network side model: PCR interval ticks and logon burst transmission
`timescale 1ns/1ps
module lsrc_ncc_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic slow,
  input wire logic logon_burst_req,
  output logic pcr_tick,
  output logic logon_burst_sent
);
  logic [1:0] div;
  logic [2:0] pend;
  always_ff @(posedge mclk)
  begin
    div <= srst ? 2'h0 : div + 2'h1;
    pcr_tick <= !srst && div == 2'h3;
  end
  always_ff @(posedge mclk)
  begin
    pend <= srst ? 3'h0 : {pend[1:0], logon_burst_req};
    logon_burst_sent <= !srst && (slow ? pend[2] : pend[0]);
  end
endmodule

// file: tb/lsrc_top_tb.sv
// Self-checking bench for the logon and sync retry control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module lsrc_top_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, pcr_tick, logon_burst_sent, logon_burst_req, logon_abandon, standby_req, irq;
  logic desc_restart = 1'b0, desc_valid = 1'b0, logon_reply = 1'b0, slow = 1'b1;
  logic [7:0] desc_byte = 8'h00;
  logic coarse_burst_sent = 1'b0, coarse_correction = 1'b0, fine_burst_sent = 1'b0, fine_correction = 1'b0;
  int mismatches = 0, n_tests = 0, n_req = 0, n_abn = 0, n_stb = 0, cyc = 0;

  lsrc_top #(.CONT_KIND(8'hC1), .CORR_KIND(8'hC2)) u_lsrc_top (.mclk(mclk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .desc_restart(desc_restart), .desc_valid(desc_valid), .desc_byte(desc_byte), .pcr_tick(pcr_tick),
    .logon_burst_sent(logon_burst_sent), .logon_reply(logon_reply), .coarse_burst_sent(coarse_burst_sent),
    .coarse_correction(coarse_correction), .fine_burst_sent(fine_burst_sent),
    .fine_correction(fine_correction), .logon_burst_req(logon_burst_req), .logon_abandon(logon_abandon),
    .standby_req(standby_req), .irq(irq));
  lsrc_ncc_model u_lsrc_ncc_model (.mclk(mclk), .srst(srst), .slow(slow), .logon_burst_req(logon_burst_req),
    .pcr_tick(pcr_tick), .logon_burst_sent(logon_burst_sent));

  initial
  begin
    forever #4 mclk = ~mclk;
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Pulse counters and watchdog; a hang counts as a mismatch
  always @(posedge mclk)
  begin
    cyc++;
    if (!srst && logon_burst_req === 1'b1) n_req++;
    if (!srst && logon_abandon === 1'b1) n_abn++;
    if (!srst && standby_req === 1'b1) n_stb++;
    if (cyc == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Request held until waitrequest is seen low at a rising edge
  task avm(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    avm(1'b1, a, d);
  endtask

  task chk_rd(input logic [5:0] a, input logic [31:0] e);
    avm(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  task desc(input logic [7:0] k, input logic [79:0] body);
    desc_valid <= 1'b1;
    desc_byte <= k;
    @(posedge mclk);
    desc_byte <= 8'h0A;
    @(posedge mclk);
    // No reserved bits, fields MSB first
    for (int i = 9; i >= 0; i--)
    begin
      desc_byte <= body[i*8 +: 8];
      @(posedge mclk);
    end
    desc_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task burst(input logic f, input logic corr);
    coarse_burst_sent <= !f;
    fine_burst_sent <= f;
    @(posedge mclk);
    coarse_burst_sent <= 1'b0;
    fine_burst_sent <= 1'b0;
    repeat (2) @(posedge mclk);
    coarse_correction <= corr && !f;
    fine_correction <= corr && f;
    @(posedge mclk);
    coarse_correction <= 1'b0;
    fine_correction <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask

  task t_reset();
    chk_rd(lsrc_pkg::OFS_CONT_WAIT, 32'hFFFFFFFF);
    chk_rd(lsrc_pkg::OFS_CONT_LIMIT, 32'h00000001);
    chk_rd(lsrc_pkg::OFS_BACKOFF, 32'h00000000);
    chk_rd(lsrc_pkg::OFS_COUNTS, 32'h01000000);
    chk_rd(6'h3C, 32'h00000000);
    `CHK(irq, 1'b0)
  endtask

  task t_desc();
    desc_restart <= 1'b1;
    @(posedge mclk);
    desc_restart <= 1'b0;
    desc(8'h55, {8'hC1, 8'h0A, 64'h0});
    desc(8'hC1, {8'h07, 32'h5, 8'h09, 32'h7});
    chk_rd(lsrc_pkg::OFS_CONT_WAIT, 32'hFFFFFFFF);
    desc(8'hC1, {8'h00, 32'h3, 8'h02, 32'h0});
    desc(8'hC2, {32'h3, 32'h2, 8'h02, 8'h01});
    wr(lsrc_pkg::OFS_FINE_WAIT, 32'h0);
    chk_rd(lsrc_pkg::OFS_CONT_WAIT, 32'h00000003);
    chk_rd(lsrc_pkg::OFS_CONT_LIMIT, 32'h00000002);
    chk_rd(lsrc_pkg::OFS_BACKOFF, 32'h00000000);
    chk_rd(lsrc_pkg::OFS_COARSE_WAIT, 32'h00000003);
    chk_rd(lsrc_pkg::OFS_FINE_WAIT, 32'h00000002);
    chk_rd(lsrc_pkg::OFS_LOSS_LIMITS, 32'h00000102);
    chk_rd(lsrc_pkg::OFS_STATUS, 32'h00000040);
  endtask

  task t_logon();
    wr(lsrc_pkg::OFS_STATUS, 32'h7F);
    wr(lsrc_pkg::OFS_MASK, 32'h7F);
    wr(lsrc_pkg::OFS_CTRL, 32'h1);
    wr(lsrc_pkg::OFS_CTRL, 32'h3);
    repeat (150) @(posedge mclk);
    `CHK(n_req, 2)
    `CHK(n_abn, 1)
    `CHK(irq, 1'b1)
    chk_rd(lsrc_pkg::OFS_STATUS, 32'h00000003);
    avm(1'b0, lsrc_pkg::OFS_COUNTS, 32'h0);
    `CHK(q[27:24], 4'h1)
    `CHK(q[7:0], 8'h02)
    wr(lsrc_pkg::OFS_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(lsrc_pkg::OFS_MASK, 32'h7F);
    wr(lsrc_pkg::OFS_STATUS, 32'h03);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    slow <= 1'b0;
    wr(lsrc_pkg::OFS_CTRL, 32'h3);
    repeat (5) @(posedge mclk);
    logon_reply <= 1'b1;
    @(posedge mclk);
    logon_reply <= 1'b0;
    repeat (100) @(posedge mclk);
    `CHK(n_req, 3)
    chk_rd(lsrc_pkg::OFS_STATUS, 32'h00000004);
  endtask

  task t_sync();
    wr(lsrc_pkg::OFS_STATUS, 32'h7F);
    burst(1'b0, 1'b0);
    avm(1'b0, lsrc_pkg::OFS_COUNTS, 32'h0);
    `CHK(q[15:8], 8'h01)
    burst(1'b0, 1'b1);
    avm(1'b0, lsrc_pkg::OFS_COUNTS, 32'h0);
    `CHK(q[15:8], 8'h00)
    `CHK(n_stb, 0)
    burst(1'b0, 1'b0);
    burst(1'b0, 1'b0);
    `CHK(n_stb, 1)
    chk_rd(lsrc_pkg::OFS_STATUS, 32'h00000028);
    wr(lsrc_pkg::OFS_STATUS, 32'h7F);
    burst(1'b1, 1'b0);
    `CHK(n_stb, 2)
    chk_rd(lsrc_pkg::OFS_STATUS, 32'h00000030);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_desc();
    t_logon();
    t_sync();
    print_verdict();
  end
endmodule
